// ==== rtl/counter_result_status_defines.svh ====
// named constants of the counter result status readout
`ifndef COUNTER_RESULT_STATUS_DEFINES_SVH
`define COUNTER_RESULT_STATUS_DEFINES_SVH
`define CRS_READ_OPCODE 8'h96
`define CRS_SUB_ROOT_KEY_WRITE 8'h00
`define CRS_SUB_SESSION_KEY_UPDATE 8'h01
`define CRS_SUB_COUNTER_INCREMENT 8'h02
`define CRS_SUB_COUNTER_READ 8'h03
`define CRS_BIT_BUSY 0
`define CRS_BIT_AUTH 1
`define CRS_BIT_REQ 2
`define CRS_BIT_INIT 3
`define CRS_BIT_DATA 4
`define CRS_BIT_FATAL 5
`define CRS_BIT_DONE 7
`define CRS_POWER_ON 8'h00
`define CRS_SUCCESS 8'h80
`define CRS_BUSY 8'h01
`define CRS_TAG_BITS 96
`define CRS_COUNTER_BITS 32
`define CRS_SIG_BITS 256
`define CRS_PAYLOAD_BYTES 6'h30
`define CRS_LAST_BIT 3'h7
`define CRS_FIRST_BIT 3'h0
`endif

// ==== rtl/counter_result_status_pkg.sv ====
// types of the counter result status readout
`include "counter_result_status_defines.svh"
package counter_result_status_pkg;
  typedef logic [7:0] status_type;
  typedef logic [7:0] sub_code_type;
  typedef logic [`CRS_TAG_BITS+`CRS_COUNTER_BITS+`CRS_SIG_BITS-1:0] payload_type;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b001,
    ST_REPLY = 3'b010,
    ST_IGNORE = 3'b100
  } link_state_type;
endpackage : counter_result_status_pkg

// ==== rtl/readout_if.sv ====
// snapshot carried from the status core to the serial link
interface readout_if;
  import counter_result_status_pkg::*;
  status_type status;
  payload_type payload;
  logic payload_ok;
  modport core (output status, output payload, output payload_ok);
  modport link (input status, input payload, input payload_ok);
endinterface : readout_if

// ==== rtl/status_link.sv ====
// serial clock side: opcode decode and reply shifter
`include "counter_result_status_defines.svh"
module status_link (
  input wire logic sclk_i,
  input wire logic link_rst_n_i,
  input wire logic mosi_i,
  readout_if.link snap,
  output logic miso_o,
  output logic miso_oe_n_o
);
  import counter_result_status_pkg::*;
  link_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_r;
  logic [5:0] byte_idx_r;
  logic [7:0] tx_r;
  wire [7:0] rx_byte = {rx_r, mosi_i};
  wire byte_end = (bit_cnt_r == `CRS_LAST_BIT);
  wire is_read = (rx_byte == `CRS_READ_OPCODE);
  wire busy = snap.status[`CRS_BIT_BUSY];
  wire in_payload = snap.payload_ok && !busy && (byte_idx_r != 6'h00) && (byte_idx_r <= `CRS_PAYLOAD_BYTES);
  wire [5:0] pay_idx = byte_idx_r - 6'h01;
  wire [7:0] pay_byte = snap.payload[$bits(payload_type)-1-8*pay_idx -: 8];
  wire [7:0] reply_byte = in_payload ? pay_byte : snap.status;
  always_ff @(posedge sclk_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
    begin
      state_r <= ST_OPCODE;
      bit_cnt_r <= `CRS_FIRST_BIT;
      rx_r <= 7'h00;
      byte_idx_r <= 6'h00;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r <= rx_byte[6:0];
      case (state_r)
        ST_OPCODE:
          if (byte_end)
            state_r <= is_read ? ST_REPLY : ST_IGNORE;
        ST_REPLY:
          if (byte_end && byte_idx_r <= `CRS_PAYLOAD_BYTES)
            byte_idx_r <= byte_idx_r + 6'h01;
        ST_IGNORE:
          state_r <= ST_IGNORE;
        default:
          state_r <= ST_OPCODE;
      endcase
    end
  end
  always_ff @(negedge sclk_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
    begin
      tx_r <= 8'h00;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end
    else if (state_r == ST_REPLY)
    begin
      miso_oe_n_o <= 1'b0;
      if (bit_cnt_r == `CRS_FIRST_BIT)
      begin
        tx_r <= {reply_byte[6:0], 1'b0};
        miso_o <= reply_byte[7];
      end
      else
      begin
        tx_r <= {tx_r[6:0], 1'b0};
        miso_o <= tx_r[7];
      end
    end
  end
endmodule : status_link

// ==== rtl/counter_result_status_readout.sv ====
// keyed counter result status register and its serial status/data readout
// Contract
// - status/data read opcode returns last keyed command status, or its counter data.
// - successful keyed command reports status with only bit 7 set.
// - successful counter read request: status followed by tag, counter, signature.
// - while busy, status repeats every byte until chip select rises; no payload.
// - reserved sub-command sets bit 2, clears bit 7.
// - root key write: bit 1 overwrite/address/truncated signature; bit 2 payload size.
// - session key update: bit 1 counter uninitialized; bit 2 signature/address/size.
// - increment: bit 3 uninitialized, bit 4 value mismatch, bit 2 signature/address/size.
// - counter read: bit 2 signature/address/size; bit 3 key or counter uninitialized.
// - status holds its last value until a keyed counter command starts or finishes while busy, or fatal is raised.
`include "counter_result_status_defines.svh"
module counter_result_status_readout (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic cmd_start_i,
  input wire counter_result_status_pkg::sub_code_type cmd_sub_i,
  input wire logic cmd_done_i,
  input wire logic err_key_overwrite_i,
  input wire logic err_addr_range_i,
  input wire logic err_sig_mismatch_i,
  input wire logic err_payload_size_i,
  input wire logic err_counter_uninit_i,
  input wire logic err_key_uninit_i,
  input wire logic err_counter_mismatch_i,
  input wire logic fatal_i,
  input wire logic [`CRS_TAG_BITS-1:0] tag_i,
  input wire logic [`CRS_COUNTER_BITS-1:0] counter_i,
  input wire logic [`CRS_SIG_BITS-1:0] signature_i,
  output counter_result_status_pkg::status_type status_o
);
  import counter_result_status_pkg::*;

  // status byte for a finished keyed command; no flag set means success
  function automatic status_type result_status(
    input sub_code_type sub,
    input logic ko,
    input logic ar,
    input logic sm,
    input logic ps,
    input logic cu,
    input logic ku,
    input logic cm
  );
    status_type s;
    s = `CRS_POWER_ON;
    case (sub)
      `CRS_SUB_ROOT_KEY_WRITE:
      begin
        s[`CRS_BIT_AUTH] = ko | ar | sm;
        s[`CRS_BIT_REQ] = ps;
      end
      `CRS_SUB_SESSION_KEY_UPDATE:
      begin
        s[`CRS_BIT_AUTH] = cu;
        s[`CRS_BIT_REQ] = sm | ar | ps;
      end
      `CRS_SUB_COUNTER_INCREMENT:
      begin
        s[`CRS_BIT_INIT] = ku | cu;
        s[`CRS_BIT_DATA] = cm;
        s[`CRS_BIT_REQ] = sm | ar | ps;
      end
      `CRS_SUB_COUNTER_READ:
      begin
        s[`CRS_BIT_REQ] = sm | ar | ps;
        s[`CRS_BIT_INIT] = ku | cu;
      end
      default:
        s[`CRS_BIT_REQ] = 1'b1;
    endcase
    if (s == `CRS_POWER_ON)
      s = `CRS_SUCCESS;
    result_status = s;
  endfunction : result_status

  status_type status_r;
  status_type status_nxt;
  sub_code_type sub_r;
  logic fatal_r;
  logic pay_ok_r;
  payload_type payload_r;

  logic cs_meta_r;
  logic cs_sync_r;
  status_type snap_status_r;
  payload_type snap_payload_r;
  logic snap_ok_r;
  readout_if snap_bus ();

  // status update: start wins over done, done only counts while busy
  wire reserved_start = cmd_start_i && (cmd_sub_i > `CRS_SUB_COUNTER_READ);
  wire fatal_now = fatal_r | fatal_i;
  wire done_while_busy = cmd_done_i && status_r[`CRS_BIT_BUSY];
  wire status_type done_status = result_status(sub_r, err_key_overwrite_i, err_addr_range_i, err_sig_mismatch_i,
                                               err_payload_size_i, err_counter_uninit_i, err_key_uninit_i,
                                               err_counter_mismatch_i);
  wire status_type reserved_status = result_status(cmd_sub_i, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  wire status_type start_status = reserved_start ? reserved_status : `CRS_BUSY;
  wire status_type base_status = cmd_start_i ? start_status : done_while_busy ? done_status : status_r;

  // payload kept only for a clean counter read request; start or fatal drops it
  wire read_ok = done_while_busy && !cmd_start_i && (sub_r == `CRS_SUB_COUNTER_READ) &&
                 (done_status == `CRS_SUCCESS) && !fatal_now;
  wire pay_ok_nxt = cmd_start_i ? 1'b0 : read_ok ? 1'b1 : fatal_now ? 1'b0 : pay_ok_r;

  // link logic held in reset whenever chip select is high
  wire link_rst_n = rstn_i & ~spi_cs_n_i;

  always_comb
  begin
    status_nxt = base_status;
    if (fatal_now)
    begin
      status_nxt[`CRS_BIT_FATAL] = 1'b1;
      status_nxt[`CRS_BIT_DONE] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      status_r <= `CRS_POWER_ON;
    else
      status_r <= status_nxt;
  end

  // sticky fatal flag, cleared only by reset
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fatal_r <= 1'b0;
    else
      fatal_r <= fatal_now;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sub_r <= `CRS_SUB_ROOT_KEY_WRITE;
    else if (cmd_start_i)
      sub_r <= cmd_sub_i;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pay_ok_r <= 1'b0;
    else
      pay_ok_r <= pay_ok_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      payload_r <= '0;
    else if (read_ok)
      payload_r <= {tag_i, counter_i, signature_i};
  end

  // chip select brought into the core clock domain
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
    end
    else
    begin
      cs_meta_r <= spi_cs_n_i;
      cs_sync_r <= cs_meta_r;
    end
  end

  // snapshot frozen while a frame is open, so the link reads stable words
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      snap_status_r <= `CRS_POWER_ON;
    else if (cs_sync_r)
      snap_status_r <= status_r;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      snap_payload_r <= '0;
    else if (cs_sync_r)
      snap_payload_r <= payload_r;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      snap_ok_r <= 1'b0;
    else if (cs_sync_r)
      snap_ok_r <= pay_ok_r && (status_r == `CRS_SUCCESS);
  end

  assign snap_bus.status = snap_status_r;
  assign snap_bus.payload = snap_payload_r;
  assign snap_bus.payload_ok = snap_ok_r;
  assign status_o = status_r;

  status_link u_link (
    .sclk_i(spi_sclk_i),
    .link_rst_n_i(link_rst_n),
    .mosi_i(spi_mosi_i),
    .snap(snap_bus),
    .miso_o(spi_miso_o),
    .miso_oe_n_o(spi_miso_oe_n_o)
  );
endmodule : counter_result_status_readout

// ==== verif/crs_assertions.sv ====
// assertions on the status readout ports
module crs_assertions (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_start_i,
  input wire counter_result_status_pkg::sub_code_type cmd_sub_i,
  input wire logic cmd_done_i,
  input wire logic err_key_overwrite_i,
  input wire logic err_counter_uninit_i,
  input wire logic err_key_uninit_i,
  input wire logic err_counter_mismatch_i,
  input wire logic fatal_i,
  input wire counter_result_status_pkg::status_type status_o
);
  import counter_result_status_pkg::*;
  sub_code_type sub_r;
  logic fin;
  assign fin = cmd_done_i && status_o[0] && !cmd_start_i;
  always_ff @(posedge ref_clk_i)
    if (cmd_start_i)
      sub_r <= cmd_sub_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_BUSY: assert property (cmd_start_i && cmd_sub_i < 8'h04 |=> status_o[0])
    else $error("no busy");
  AST_RSVD: assert property (cmd_start_i && cmd_sub_i > 8'h03 |=> status_o[2] && !status_o[7])
    else $error("reserved");
  AST_OK: assert property (status_o[7] |-> status_o[6:0] == 7'h00)
    else $error("success");
  AST_HOLD: assert property (!cmd_start_i && !fin && !fatal_i |=> $stable(status_o))
    else $error("hold");
  AST_KEY: assert property (fin && sub_r == 8'h00 && err_key_overwrite_i |=> status_o[1])
    else $error("key");
  AST_SES: assert property (fin && sub_r == 8'h01 && err_counter_uninit_i |=> status_o[1])
    else $error("session");
  AST_INC: assert property (fin && sub_r == 8'h02 && err_counter_mismatch_i |=> status_o[4])
    else $error("increment");
  AST_REQ: assert property (fin && sub_r == 8'h03 && err_key_uninit_i |=> status_o[3])
    else $error("request");
  AST_FATAL: assert property (fatal_i |=> status_o[5] && !status_o[7])
    else $error("fatal");
  cover property (fin && sub_r == 8'h03);
  cover property (cmd_start_i && cmd_sub_i > 8'h03);
  cover property (fatal_i);
endmodule : crs_assertions
bind counter_result_status_readout crs_assertions u_crs_assertions (.ref_clk_i, .rstn_i, .cmd_start_i,
  .cmd_sub_i, .cmd_done_i, .err_key_overwrite_i, .err_counter_uninit_i, .err_key_uninit_i,
  .err_counter_mismatch_i, .fatal_i, .status_o);

// ==== verif/spi_host_model.sv ====
// serial host model issuing read frames
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx [0:63];
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // opcode out, then n reply bytes in; clock still outside frames
  task automatic frame(input logic [7:0] op, input int n);
    #50 cs_n_o = 1'b0;
    for (int i = 0; i < 8 + 8 * n; i++)
    begin
      mosi_o = (i < 8) ? op[7 - i] : ~mosi_o;
      #16 sclk_o = 1'b1;
      if (i >= 8)
        rx[i / 8 - 1][7 - i % 8] = miso_i;
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : frame
endmodule : spi_host_model

// ==== verif/test_counter_result_status_readout.sv ====
// self-checking bench for the counter result status readout
`include "counter_result_status_defines.svh"
module test_counter_result_status_readout;
  timeunit 1ns;
  timeprecision 100ps;
  import counter_result_status_pkg::*;
  logic ref_clk_i, rstn_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_n_o, miso_w;
  logic cmd_start_i, cmd_done_i, fatal_i;
  logic [6:0] err;
  sub_code_type cmd_sub_i;
  logic [`CRS_TAG_BITS-1:0] tag_i;
  logic [`CRS_COUNTER_BITS-1:0] counter_i;
  logic [`CRS_SIG_BITS-1:0] signature_i;
  status_type status_o;
  int error_cnt, n_checks, seed;
  assign miso_w = spi_miso_oe_n_o ? ~spi_miso_o : spi_miso_o;
  counter_result_status_readout u_counter_result_status_readout (.ref_clk_i, .rstn_i, .spi_sclk_i,
    .spi_cs_n_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_n_o, .cmd_start_i, .cmd_sub_i, .cmd_done_i,
    .err_key_overwrite_i(err[0]), .err_addr_range_i(err[1]), .err_sig_mismatch_i(err[2]),
    .err_payload_size_i(err[3]), .err_counter_uninit_i(err[4]), .err_key_uninit_i(err[5]),
    .err_counter_mismatch_i(err[6]), .fatal_i, .tag_i, .counter_i, .signature_i, .status_o);
  spi_host_model u_spi_host_model (.sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i), .miso_i(miso_w));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input status_type seen, input status_type exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  function automatic logic [6:0] mask(input int s);
    return (s == 0) ? 7'h0f : (s == 1) ? 7'h1e : (s == 2) ? 7'h7e : 7'h3e;
  endfunction : mask
  function automatic status_type expect_status(input sub_code_type s, input logic [6:0] e);
    status_type r;
    case (s)
      8'h00: r = {5'h00, e[3], |e[2:0], 1'b0};
      8'h01: r = {5'h00, |e[3:1], e[4], 1'b0};
      8'h02: r = {3'h0, e[6], e[5] | e[4], |e[3:1], 2'h0};
      default: r = {4'h0, e[5] | e[4], |e[3:1], 2'h0};
    endcase
    return (r == 8'h00) ? 8'h80 : r;
  endfunction : expect_status
  task automatic run_cmd(input sub_code_type s, input logic [6:0] e);
    status_type x;
    payload_type p;
    int n;
    x = (s > 8'h03) ? 8'h04 : 8'h01;
    for (int k = 0; k < 12; k++)
      p[32 * k +: 32] = $random(seed);
    @(posedge ref_clk_i);
    cmd_start_i <= 1'b1;
    cmd_sub_i <= s;
    @(posedge ref_clk_i);
    cmd_start_i <= 1'b0;
    #1 check(status_o, x);
    u_spi_host_model.frame(`CRS_READ_OPCODE, 3);
    for (int k = 0; k < 3; k++)
      check(u_spi_host_model.rx[k], x);
    @(posedge ref_clk_i);
    {tag_i, counter_i, signature_i} <= p;
    err <= e;
    cmd_done_i <= 1'b1;
    @(posedge ref_clk_i);
    err <= ~e;
    if (s < 8'h04)
      x = expect_status(s, e);
    #1 check(status_o, x);
    @(posedge ref_clk_i);
    cmd_done_i <= 1'b0;
    #1 check(status_o, x);
    n = (x == 8'h80 && s == 8'h03) ? 49 : 2;
    u_spi_host_model.frame(`CRS_READ_OPCODE, n);
    check(u_spi_host_model.rx[0], x);
    for (int k = 1; k < n; k++)
      check(u_spi_host_model.rx[k], (n == 2) ? x : p[384 - 8 * k +: 8]);
  endtask : run_cmd
  initial
  begin
    seed = 32'h8a97f264;
    {rstn_i, cmd_start_i, cmd_done_i, fatal_i, err, cmd_sub_i} = '0;
    {tag_i, counter_i, signature_i} = '0;
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 check(status_o, 8'h00);
    u_spi_host_model.frame(`CRS_READ_OPCODE, 1);
    check(u_spi_host_model.rx[0], 8'h00);
    u_spi_host_model.frame(8'h05, 1);
    check(u_spi_host_model.rx[0], 8'hff);
    #1 check({7'h00, spi_miso_oe_n_o}, 8'h01);
    for (int i = 0; i < 16; i++)
      run_cmd(8'(i % 4), (i < 4) ? 7'h00 : mask(i % 4) & ((i < 8) ? 7'h7f : 7'($random(seed))));
    run_cmd(8'h04 | 8'($random(seed)), 7'h7f);
    @(posedge ref_clk_i);
    fatal_i <= 1'b1;
    @(posedge ref_clk_i);
    fatal_i <= 1'b0;
    #1 check(status_o & 8'ha0, 8'h20);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 check(status_o, 8'h00);
    u_spi_host_model.frame(`CRS_READ_OPCODE, 1);
    check(u_spi_host_model.rx[0], 8'h00);
    complete_run();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    error_cnt++;
    complete_run();
  end
endmodule : test_counter_result_status_readout
